// ===== e1lp_pkg.sv
// Constants and types shared by the E1 line-side dual-rail port
package e1lp_pkg;
	// Time base
	localparam int CLK_PS = 5000;
	localparam int BIT_PS = 488281;
	localparam int BIT_CYC = BIT_PS / CLK_PS;
	localparam int PULSE_CYC = BIT_CYC / 2;
	localparam int LOS_BITS = 32;
	localparam int LOS_CYC = LOS_BITS * BIT_CYC;
	localparam int CNT_W = 12;
	// Transmit buffer
	localparam int FIFO_DEPTH = 32;
	localparam int SYM_W = 2;
	localparam int SYM_POS = 0;
	localparam int SYM_NEG = 1;
	// Positions in the synchroniser vector
	localparam int PIN_N = 6;
	localparam int IN_MODE = 0;
	localparam int IN_TXP = 1;
	localparam int IN_TXN = 2;
	localparam int IN_TCK = 3;
	localparam int IN_RXP = 4;
	localparam int IN_RXN = 5;

	typedef enum logic [1:0] {
		E1LP_IDLE = 2'b00,
		E1LP_MARK = 2'b01,
		E1LP_SPACE = 2'b10
	} e1lp_tx_e;
endpackage

// ===== e1lp_port.sv
// E1 line-side dual-rail port: transmit buffer and top level
`timescale 1ns/10ps

module e1lp_fifo #(
	parameter int W = 2,
	parameter int D = 32
) (
	input wire logic mclk_i, // Core clock
	input wire logic rst_n_i, // Synchronous reset, low
	input wire logic in_valid_i, // Write request
	output logic in_ready_o, // Space available
	input wire logic [W-1:0] in_data_i, // Write data
	output logic out_valid_o, // Data available
	input wire logic out_ready_i, // Read accept
	output logic [W-1:0] out_data_o // Head entry
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} e1lp_fifo_s;

	e1lp_fifo_s s_r;
	e1lp_fifo_s s_nxt;
	logic push;
	logic pop;

	assign in_ready_o = (s_r.cnt != (AW+1)'(D));
	assign out_valid_o = (s_r.cnt != '0);
	assign out_data_o = s_r.mem[s_r.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_ready_i && out_valid_o;

	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.mem[s_r.wr] = in_data_i;
			s_nxt.wr = s_r.wr + 1'b1;
		end
		if (pop)
			s_nxt.rd = s_r.rd + 1'b1;
		if (push && !pop)
			s_nxt.cnt = s_r.cnt + 1'b1;
		else if (pop && !push)
			s_nxt.cnt = s_r.cnt - 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule // e1lp_fifo

module e1lp_port (
	input wire logic mclk_i, // Core clock, 200 MHz
	input wire logic rst_n_i, // Synchronous reset, low
	input wire logic clocked_mode_i, // 1 clocked, 0 clockless
	input wire logic transmit_positive_data_in_i, // Framer positive data
	input wire logic transmit_negative_data_in_i, // Framer negative data
	input wire logic transmit_sample_clock_in_i, // Framer transmit clock
	input wire logic line_pos_pulse_i, // Sliced positive line pulse
	input wire logic line_neg_pulse_i, // Sliced negative line pulse
	output logic line_out_plus_o, // Positive line drive
	output logic line_out_minus_o, // Negative line drive
	output logic receive_positive_pulse_out_o, // Positive pulse seen
	output logic receive_negative_pulse_out_o, // Negative pulse seen
	output logic signal_lost_flag_out_o, // Loss of signal
	output logic tx_ready_o, // Transmit buffer has room
	output logic tx_drop_o // Symbol lost, buffer full
);
	import e1lp_pkg::*;

	typedef struct packed {
		logic [PIN_N-1:0] sync1;
		logic [PIN_N-1:0] sync2;
		logic [PIN_N-1:0] prev;
		e1lp_tx_e st;
		logic [CNT_W-1:0] tx_cnt;
		logic plus;
		logic minus;
		logic rxp;
		logic rxn;
		logic los;
		logic [CNT_W-1:0] los_cnt;
		logic ready;
		logic drop;
	} e1lp_port_s;

	e1lp_port_s s_r;
	e1lp_port_s s_nxt;
	logic [PIN_N-1:0] pins;
	logic take;
	logic [SYM_W-1:0] sym_in;
	logic in_ready;
	logic out_valid;
	logic [SYM_W-1:0] out_sym;
	logic pop_rdy;
	logic fall_tck;
	logic rise_p;
	logic rise_n;
	logic rx_edge_p;
	logic rx_edge_n;

	assign pins = {line_neg_pulse_i, line_pos_pulse_i,
		transmit_sample_clock_in_i, transmit_negative_data_in_i,
		transmit_positive_data_in_i, clocked_mode_i};

	// Edges come from the second stage against a third, never the first
	assign fall_tck = s_r.prev[IN_TCK] & ~s_r.sync2[IN_TCK];
	assign rise_p = s_r.sync2[IN_TXP] & ~s_r.prev[IN_TXP];
	assign rise_n = s_r.sync2[IN_TXN] & ~s_r.prev[IN_TXN];
	assign rx_edge_p = s_r.sync2[IN_RXP] & ~s_r.prev[IN_RXP];
	assign rx_edge_n = s_r.sync2[IN_RXN] & ~s_r.prev[IN_RXN];
	assign pop_rdy = (s_r.st == E1LP_IDLE);

	always_comb
	begin
		if (s_r.sync2[IN_MODE])
		begin
			// Spaces are pushed too so bit timing is kept
			take = fall_tck;
			sym_in = {s_r.sync2[IN_TXN], s_r.sync2[IN_TXP]};
		end
		else
		begin
			// Clock input ignored here; each RZ pulse is one mark
			take = rise_p | rise_n;
			sym_in = {rise_n, rise_p};
		end
	end

	e1lp_fifo #(
		.W(SYM_W),
		.D(FIFO_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(take),
		.in_ready_o(in_ready),
		.in_data_i(sym_in),
		.out_valid_o(out_valid),
		.out_ready_i(pop_rdy),
		.out_data_o(out_sym)
	);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		s_nxt.ready = in_ready;
		s_nxt.drop = take & ~in_ready;
		s_nxt.rxp = rx_edge_p;
		s_nxt.rxn = rx_edge_n;
		if (rx_edge_p || rx_edge_n)
		begin
			s_nxt.los_cnt = '0;
			s_nxt.los = 1'b0;
		end
		else if (s_r.los_cnt == CNT_W'(LOS_CYC - 1))
			s_nxt.los = 1'b1;
		else
			s_nxt.los_cnt = s_r.los_cnt + 1'b1;
		unique case (s_r.st)
			E1LP_IDLE:
			begin
				if (out_valid)
				begin
					// A symbol with both rails set is sent as a space
					s_nxt.plus = out_sym[SYM_POS] & ~out_sym[SYM_NEG];
					s_nxt.minus = out_sym[SYM_NEG] & ~out_sym[SYM_POS];
					s_nxt.tx_cnt = CNT_W'(PULSE_CYC - 1);
					s_nxt.st = E1LP_MARK;
				end
			end
			E1LP_MARK:
			begin
				if (s_r.tx_cnt == '0)
				begin
					s_nxt.plus = 1'b0;
					s_nxt.minus = 1'b0;
					s_nxt.tx_cnt = CNT_W'(BIT_CYC - PULSE_CYC - 2);
					s_nxt.st = E1LP_SPACE;
				end
				else
					s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
			end
			E1LP_SPACE:
			begin
				if (s_r.tx_cnt == '0)
					s_nxt.st = E1LP_IDLE;
				else
					s_nxt.tx_cnt = s_r.tx_cnt - 1'b1;
			end
			default:
				s_nxt.st = E1LP_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign line_out_plus_o = s_r.plus;
	assign line_out_minus_o = s_r.minus;
	assign receive_positive_pulse_out_o = s_r.rxp;
	assign receive_negative_pulse_out_o = s_r.rxn;
	assign signal_lost_flag_out_o = s_r.los;
	assign tx_ready_o = s_r.ready;
	assign tx_drop_o = s_r.drop;

	// In clocked mode every falling clock edge is either queued or reported lost
	property p_clk_sample;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(s_r.sync2[IN_MODE] && fall_tck) |=> (out_valid || tx_drop_o);
	endproperty
	a_clk_sample: assert property (p_clk_sample)
		else $error("clocked sample not taken on falling edge");

	property p_rx_pos;
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(s_r.sync2[IN_RXP]) |=>
			receive_positive_pulse_out_o ##1 !receive_positive_pulse_out_o;
	endproperty
	a_rx_pos: assert property (p_rx_pos)
		else $error("positive receive pulse missing or too long");

	property p_rx_neg;
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(s_r.sync2[IN_RXN]) |=>
			receive_negative_pulse_out_o ##1 !receive_negative_pulse_out_o;
	endproperty
	a_rx_neg: assert property (p_rx_neg)
		else $error("negative receive pulse missing or too long");

	property p_los_set;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(s_r.los_cnt == CNT_W'(LOS_CYC - 1) && !rx_edge_p && !rx_edge_n)
			|=> signal_lost_flag_out_o;
	endproperty
	a_los_set: assert property (p_los_set)
		else $error("loss of signal not flagged after silence");

	property p_los_clr;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(rx_edge_p || rx_edge_n) |=> !signal_lost_flag_out_o;
	endproperty
	a_los_clr: assert property (p_los_clr)
		else $error("loss of signal held despite line pulse");
endmodule // e1lp_port

// ===== e1lp_framer.sv
// Behavioural framer model driving the transmit rails and clock
`timescale 1ns/10ps

module e1lp_framer (
	output logic txp_o, // Positive rail
	output logic txn_o, // Negative rail
	output logic tck_o // Transmit clock
);
	initial
	begin
		txp_o = 1'b0;
		txn_o = 1'b0;
		tck_o = 1'b0;
	end

	// Rails move on the clock rise so they are settled at its fall
	task automatic send_nrz(input logic [1:0] sym);
		tck_o = 1'b1;
		{txn_o, txp_o} = (sym == 2'h3) ? 2'h0 : sym;
		#80 tck_o = 1'b0;
		#80;
	endtask

	// Clock stands still so only the rail edges carry timing
	task automatic send_rz(input logic [1:0] sym);
		tck_o = 1'b0;
		{txn_o, txp_o} = (sym == 2'h3) ? 2'h0 : sym;
		#80 {txn_o, txp_o} = 2'h0;
		#80;
	endtask
endmodule // e1lp_framer

// ===== e1lp_port_test.sv
// Self-checking bench for the E1 dual-rail port
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
	$display("unexpected %s exp %0h got %0h", n, e, s); end end

module e1lp_port_test;
	import e1lp_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, mode = 1'b1, lpos = 1'b0, lneg = 1'b0;
	logic txp, txn, tck, lp, lm, rp, rn, los, rdy, drop, lp_q = 1'b0;
	int err_total = 0, compares = 0, rises = 0, drops = 0, full = 0;

	always #2.5 mclk = ~mclk;

	e1lp_framer u_e1lp_framer (.txp_o(txp), .txn_o(txn), .tck_o(tck));
	e1lp_port u_e1lp_port (.mclk_i(mclk), .rst_n_i(rst_n),
		.clocked_mode_i(mode), .transmit_positive_data_in_i(txp),
		.transmit_negative_data_in_i(txn),
		.transmit_sample_clock_in_i(tck), .line_pos_pulse_i(lpos),
		.line_neg_pulse_i(lneg), .line_out_plus_o(lp), .line_out_minus_o(lm),
		.receive_positive_pulse_out_o(rp),
		.receive_negative_pulse_out_o(rn), .signal_lost_flag_out_o(los),
		.tx_ready_o(rdy), .tx_drop_o(drop));

	// Every offered symbol must end up either on the line or dropped
	always @(posedge mclk)
	begin
		if (lp === 1'b1 && lp_q !== 1'b1)
			rises++;
		if (drop === 1'b1)
			drops++;
		if (rdy === 1'b0)
			full++;
		lp_q <= lp;
	end

	task automatic end_sim;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic tick(input int n = 1);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic mark(input bit neg);
		int i = 0;
		int n = 0;
		while ((neg ? lm : lp) !== 1'b1 && i < 400)
		begin
			tick();
			i++;
		end
		while ((neg ? lm : lp) === 1'b1 && n < 200)
		begin
			tick();
			n++;
		end
		`CHK("mark width", PULSE_CYC, n)
		if (i == 400)
			end_sim();
	endtask

	task automatic tx_clocked;
		rises = 0;
		fork
			begin
				u_e1lp_framer.send_nrz(2'h1);
				u_e1lp_framer.send_nrz(2'h2);
				u_e1lp_framer.send_nrz(2'h3);
			end
			begin
				mark(1'b0);
				mark(1'b1);
			end
		join
		tick(2 * BIT_CYC);
		`CHK("pos marks", 1, rises)
	endtask

	task automatic tx_clockless;
		mode = 1'b0;
		tick(4);
		fork
			u_e1lp_framer.send_rz(2'h2);
			mark(1'b1);
		join
	endtask

	task automatic rx(input bit neg);
		int i = 0;
		{lneg, lpos} = neg ? 2'h2 : 2'h1;
		while ((neg ? rn : rp) !== 1'b1 && i < 8)
		begin
			tick();
			i++;
		end
		`CHK("rx delay", 3, i)
		tick();
		`CHK("rx width", 2'h0, {rn, rp})
		`CHK("los clear", 1'b0, los)
		{lneg, lpos} = 2'h0;
		tick(2);
		if (i == 8)
			end_sim();
	endtask

	task automatic los_check;
		rx(1'b0);
		tick(LOS_CYC - 100);
		`CHK("los early", 1'b0, los)
		tick(200);
		`CHK("los set", 1'b1, los)
		rx(1'b1);
	endtask

	// Framer outpaces the line three to one, so the buffer must refuse
	task automatic burst;
		mode = 1'b1;
		tick(4);
		rises = 0;
		drops = 0;
		full = 0;
		repeat (64) u_e1lp_framer.send_nrz(2'h1);
		tick(FIFO_DEPTH * BIT_CYC + 200);
		`CHK("marks", 64, rises + drops)
		`CHK("refused", 1'b1, drops > 0 && full > 0)
		`CHK("ready", 1'b1, rdy)
	endtask

	initial
	begin
		tick(2);
		rst_n = 1'b1;
		tick();
		`CHK("idle", 5'h00, {lp, lm, rp, rn, los})
		`CHK("ready", 1'b1, rdy)
		tx_clocked();
		tx_clockless();
		rx(1'b0);
		rx(1'b1);
		los_check();
		burst();
		end_sim();
	end
endmodule // e1lp_port_test
